// ===== pkg/fdm_pkg.sv
package fdm_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int NUM_CH = 2;
  localparam int CH_W = 1;
  localparam int ADDR_W = 12;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 20;
  // Frequency step in millihertz (0.02 Hz)
  localparam int FREQ_STEP_MHZ = 20;
  // Dividends: ticks per second over the step, and sixty times that per Hz
  localparam logic [39:0] K_FREQ =
    40'(64'hE8_D4A5_1000 / 64'(TICK_NS * FREQ_STEP_MHZ));
  localparam logic [39:0] K_RPM = 40'(64'hD_F847_5800 / 64'(TICK_NS));
  localparam logic [6:0] PERCENT = 7'h64;
  // Shortest period that still counts as inside the measuring range
  localparam logic [31:0] MIN_PERIOD_TICKS = 32'h0000_0002;
  localparam logic [5:0] DIV_STEPS = 6'h27;

  // ----------------------------------------------------------------
  // Register map, per channel block of 64 bytes (channel select at CH_LSB)
  // ----------------------------------------------------------------
  localparam int CH_LSB = 6;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TMO = 4'h1;
  localparam logic [3:0] REG_PPC = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_ACT = 4'h4;
  localparam logic [3:0] REG_INACT = 4'h5;
  localparam logic [3:0] REG_PER = 4'h6;
  localparam logic [3:0] REG_FREQ = 4'h7;
  localparam logic [3:0] REG_DUTY = 4'h8;
  localparam logic [3:0] REG_RPM = 4'h9;
  localparam logic [3:0] REG_CYC = 4'hA;

  // Control fields
  localparam int CTRL_POL = 0;
  localparam int CTRL_EDGE = 1;
  localparam int CTRL_CYCLE = 2;
  // Status fields
  localparam int STAT_TMO = 0;
  localparam int STAT_LVL = 1;
  localparam int STAT_REP_TMO = 2;
  localparam int STAT_BUSY = 3;

  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h1;
  localparam logic [31:0] TMO_RST = 32'h02FA_F080;
  localparam logic [15:0] PPC_RST = 16'h0001;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ctrl;
    logic [31:0] tmo;
    logic [15:0] ppc;
    logic prev;
    logic started;
    logic [31:0] act_cnt;
    logic [31:0] inact_cnt;
    logic [31:0] cyc_acc;
    logic [15:0] pcnt;
    logic [31:0] tmo_cnt;
    logic tmo_flag;
    logic [31:0] live_act;
    logic [31:0] live_inact;
    logic [31:0] live_per;
    logic [31:0] live_cyc;
    logic [31:0] live_freq;
    logic [31:0] live_duty;
    logic [31:0] live_rpm;
    logic busy;
    logic pend;
    logic [1:0] op;
    logic [5:0] step;
    logic [39:0] num;
    logic [31:0] den;
    logic [32:0] rem;
    logic rep_tmo;
    logic [31:0] rep_act;
    logic [31:0] rep_inact;
    logic [31:0] rep_per;
    logic [31:0] rep_cyc;
    logic [31:0] rep_freq;
    logic [31:0] rep_duty;
    logic [31:0] rep_rpm;
  } fdm_ch_t;

  typedef struct packed {
    fdm_ch_t [NUM_CH-1:0] ch;
    logic [31:0] rdata;
    logic slverr;
  } fdm_state_t;

endpackage

// ===== logic/fdm_measure.sv
// Functional notes
// - Duty is active time over active plus inactive time, in percent.
// - Phase and period durations count a 20 ns timebase tick.
// - Frequency is integer reciprocal of period, in 0.02 Hz steps.
// - Each channel holds its own timeout setting.
// - No input transition within the timeout declares a timeout.
// - After timeout, samples carry fixed values at the next sampling instant.
// - Timeout reports frequency and speed as zero.
// - Timeout reports duty 0% or 100% from the static input level.
// - Timeout reports active and inactive times as zero.
// - Timeout reports period duration as zero.
// - A period longer than the timeout is unmeasurable; timeout values.
// - Inputs outside measuring range get the same timeout values.
// - Cycle mode times n periods; period frequency is n times cycle's.
// - Periods per cycle converts cycle frequency to revolutions per minute.
// - Cycle mode evaluates only complete cycles.
// - Cycle result does not depend on which edge starts the cycle.
// - Each channel selects last-period or last-cycle frequency.
// - Each channel selects the edge that starts a period.
`timescale 1ns/1ps
module fdm_measure
  import fdm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [NUM_CH-1:0] sig_i,
  input wire logic sample_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  fdm_state_t st;
  fdm_state_t next_st;

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle, so no wait states
  assign prdata_o = st.rdata;
  assign pready_o = psel_i & penable_i;
  assign pslverr_o = psel_i & penable_i & st.slverr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic lvl;
    logic rise;
    logic fall;
    logic pstart;
    logic cyc_done;
    logic in_range;
    logic [32:0] rs;
    logic [33:0] trial;
    logic [31:0] q;
    logic [CH_W-1:0] sel;
    logic [3:0] idx;
    logic mapped;
    lvl = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    pstart = 1'b0;
    cyc_done = 1'b0;
    in_range = 1'b0;
    rs = '0;
    trial = '0;
    q = '0;
    sel = '0;
    idx = 4'h0;
    mapped = 1'b0;
    next_st = st;
    for (int c = 0; c < NUM_CH; c++)
    begin
      // Edge detect on the active-level view of the input
      lvl = st.ch[c].ctrl[CTRL_POL] ? sig_i[c] : ~sig_i[c];
      rise = lvl & ~st.ch[c].prev;
      fall = ~lvl & st.ch[c].prev;
      pstart = st.ch[c].ctrl[CTRL_EDGE] ? fall : rise;
      next_st.ch[c].prev = lvl;
      cyc_done = 1'b0;
      // One tick per clock; counters saturate instead of wrapping
      if (lvl && ~&st.ch[c].act_cnt)
        next_st.ch[c].act_cnt = st.ch[c].act_cnt + 32'h1;
      if (!lvl && ~&st.ch[c].inact_cnt)
        next_st.ch[c].inact_cnt = st.ch[c].inact_cnt + 32'h1;
      if (~&st.ch[c].cyc_acc)
        next_st.ch[c].cyc_acc = st.ch[c].cyc_acc + 32'h1;
      // Timeout watch, restarted by either transition
      if (rise || fall)
        next_st.ch[c].tmo_cnt = 32'h0;
      else if (~&st.ch[c].tmo_cnt)
        next_st.ch[c].tmo_cnt = st.ch[c].tmo_cnt + 32'h1;
      if (st.ch[c].tmo != 32'h0 && st.ch[c].tmo_cnt >= st.ch[c].tmo)
        next_st.ch[c].tmo_flag = 1'b1;
      // Period boundary
      if (pstart)
      begin
        next_st.ch[c].act_cnt = {31'h0, lvl};
        next_st.ch[c].inact_cnt = {31'h0, ~lvl};
        if (!st.ch[c].started)
        begin
          // First edge only opens a period; nothing is complete yet
          next_st.ch[c].started = 1'b1;
          next_st.ch[c].cyc_acc = 32'h1;
          next_st.ch[c].pcnt = 16'h0;
        end
        else
        begin
          next_st.ch[c].live_act = st.ch[c].act_cnt;
          next_st.ch[c].live_inact = st.ch[c].inact_cnt;
          next_st.ch[c].live_per = st.ch[c].act_cnt + st.ch[c].inact_cnt;
          // Cycle closes after ppc whole periods, from any start edge
          if (st.ch[c].pcnt + 16'h1 >= st.ch[c].ppc)
          begin
            next_st.ch[c].live_cyc = st.ch[c].cyc_acc;
            next_st.ch[c].cyc_acc = 32'h1;
            next_st.ch[c].pcnt = 16'h0;
            cyc_done = 1'b1;
          end
          else
            next_st.ch[c].pcnt = st.ch[c].pcnt + 16'h1;
          in_range = (st.ch[c].act_cnt + st.ch[c].inact_cnt)
            >= MIN_PERIOD_TICKS;
          if (st.ch[c].tmo != 32'h0 && (st.ch[c].act_cnt
              + st.ch[c].inact_cnt) > st.ch[c].tmo)
            in_range = 1'b0;
          next_st.ch[c].tmo_flag = ~in_range;
          // Results are recomputed per period, or per cycle in cycle mode
          if (!st.ch[c].ctrl[CTRL_CYCLE] || cyc_done)
          begin
            if (st.ch[c].busy)
              next_st.ch[c].pend = 1'b1;
            else
            begin
              next_st.ch[c].busy = 1'b1;
              next_st.ch[c].op = 2'h0;
              next_st.ch[c].step = 6'h0;
              next_st.ch[c].rem = '0;
              next_st.ch[c].num = K_FREQ;
              next_st.ch[c].den = st.ch[c].ctrl[CTRL_CYCLE]
                ? next_st.ch[c].live_cyc : next_st.ch[c].live_per;
            end
          end
        end
      end
      // Serial restoring divider: freq, then duty, then speed
      if (st.ch[c].busy)
      begin
        rs = {st.ch[c].rem[31:0], st.ch[c].num[39]};
        trial = {1'b0, rs} - {2'h0, st.ch[c].den};
        next_st.ch[c].rem = trial[33] ? rs : trial[32:0];
        next_st.ch[c].num = {st.ch[c].num[38:0], ~trial[33]};
        next_st.ch[c].step = st.ch[c].step + 6'h1;
        if (st.ch[c].step == DIV_STEPS)
        begin
          // Zero divisor gives zero rather than all ones
          q = (st.ch[c].den == 32'h0) ? 32'h0
            : next_st.ch[c].num[31:0];
          next_st.ch[c].step = 6'h0;
          next_st.ch[c].rem = '0;
          unique case (st.ch[c].op)
            2'h0:
            begin
              // Cycle result scaled back to per-period frequency
              next_st.ch[c].live_freq = st.ch[c].ctrl[CTRL_CYCLE]
                ? 32'(q * st.ch[c].ppc) : q;
              next_st.ch[c].op = 2'h1;
              next_st.ch[c].num = 40'(st.ch[c].live_act * PERCENT);
              next_st.ch[c].den = st.ch[c].live_per;
            end
            2'h1:
            begin
              next_st.ch[c].live_duty = q;
              next_st.ch[c].op = 2'h2;
              next_st.ch[c].num = K_RPM;
              next_st.ch[c].den = st.ch[c].live_cyc;
            end
            default:
            begin
              // Speed only has meaning over a whole revolution
              next_st.ch[c].live_rpm = st.ch[c].ctrl[CTRL_CYCLE]
                ? q : 32'h0;
              // A close landing on this last step is kept, and the
              // rerun takes the newest period or cycle
              next_st.ch[c].op = 2'h0;
              next_st.ch[c].busy = next_st.ch[c].pend;
              next_st.ch[c].pend = 1'b0;
              next_st.ch[c].num = K_FREQ;
              next_st.ch[c].den = st.ch[c].ctrl[CTRL_CYCLE]
                ? next_st.ch[c].live_cyc : next_st.ch[c].live_per;
            end
          endcase
        end
      end
      // Sampling instant publishes latest results or the fixed set
      if (sample_i)
      begin
        next_st.ch[c].rep_tmo = st.ch[c].tmo_flag;
        if (st.ch[c].tmo_flag)
        begin
          next_st.ch[c].rep_freq = 32'h0;
          next_st.ch[c].rep_rpm = 32'h0;
          next_st.ch[c].rep_duty = lvl ? 32'(PERCENT) : 32'h0;
          next_st.ch[c].rep_act = 32'h0;
          next_st.ch[c].rep_inact = 32'h0;
          next_st.ch[c].rep_cyc = 32'h0;
          next_st.ch[c].rep_per = 32'h0;
        end
        else
        begin
          next_st.ch[c].rep_freq = st.ch[c].live_freq;
          next_st.ch[c].rep_rpm = st.ch[c].live_rpm;
          next_st.ch[c].rep_duty = st.ch[c].live_duty;
          next_st.ch[c].rep_act = st.ch[c].live_act;
          next_st.ch[c].rep_inact = st.ch[c].live_inact;
          next_st.ch[c].rep_cyc = st.ch[c].live_cyc;
          next_st.ch[c].rep_per = st.ch[c].live_per;
        end
      end
    end
    // APB decode
    sel = paddr_i[CH_LSB +: CH_W];
    idx = paddr_i[5:2];
    mapped = (paddr_i[ADDR_W-1:CH_LSB+CH_W] == '0)
      && (paddr_i[1:0] == 2'h0) && (idx <= REG_CYC);
    // Read data captured in setup so it stands through the access phase
    if (psel_i && !penable_i)
    begin
      next_st.slverr = ~mapped;
      next_st.rdata = 32'h0;
      if (mapped)
      begin
        unique case (idx)
          REG_CTRL: next_st.rdata = {29'h0, st.ch[sel].ctrl};
          REG_TMO: next_st.rdata = st.ch[sel].tmo;
          REG_PPC: next_st.rdata = {16'h0, st.ch[sel].ppc};
          REG_STAT:
          begin
            next_st.rdata[STAT_TMO] = st.ch[sel].tmo_flag;
            next_st.rdata[STAT_LVL] = st.ch[sel].prev;
            next_st.rdata[STAT_REP_TMO] = st.ch[sel].rep_tmo;
            next_st.rdata[STAT_BUSY] = st.ch[sel].busy;
          end
          REG_ACT: next_st.rdata = st.ch[sel].rep_act;
          REG_INACT: next_st.rdata = st.ch[sel].rep_inact;
          REG_PER: next_st.rdata = st.ch[sel].rep_per;
          REG_FREQ: next_st.rdata = st.ch[sel].rep_freq;
          REG_DUTY: next_st.rdata = st.ch[sel].rep_duty;
          REG_RPM: next_st.rdata = st.ch[sel].rep_rpm;
          default: next_st.rdata = st.ch[sel].rep_cyc;
        endcase
      end
    end
    // Writes take effect in the access cycle; a CTRL or PPC write restarts
    // the channel's counting; a division under way still finishes under the new mode and ppc
    if (psel_i && penable_i && pwrite_i && mapped)
    begin
      if (idx == REG_CTRL)
      begin
        next_st.ch[sel].ctrl = pwdata_i[2:0];
        next_st.ch[sel].started = 1'b0;
      end
      if (idx == REG_TMO)
        next_st.ch[sel].tmo = pwdata_i;
      if (idx == REG_PPC)
      begin
        next_st.ch[sel].ppc = pwdata_i[15:0];
        next_st.ch[sel].started = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st <= '0;
      for (int c = 0; c < NUM_CH; c++)
      begin
        st.ch[c].ctrl <= CTRL_RST;
        st.ch[c].tmo <= TMO_RST;
        st.ch[c].ppc <= PPC_RST;
      end
    end
    else
      st <= next_st;
  end

endmodule

// ===== verif/fdm_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Bus and result-format checks at the pins
// ------------------------------------------------
module fdm_checker
  import fdm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [NUM_CH-1:0] sig_i,
  input wire logic sample_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o
);
  logic setup;
  logic acc;
  logic mapped;
  // Bus phases and an in-map decode, so each property stays short
  assign setup = psel_i && !penable_i;
  assign acc = psel_i && penable_i;
  assign mapped = paddr_i[11:7] == 5'h00 && paddr_i[1:0] == 2'h0
    && paddr_i[5:2] <= 4'hA;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  property p_rdy;
    setup ##1 acc |-> pready_o;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("no ready in access phase");
  property p_quiet;
    !acc |-> !pslverr_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("error flag outside access phase");
  property p_hold;
    !setup |=> $stable(prdata_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved outside setup");
  property p_low;
    setup && paddr_i[1:0] != 2'h0 ##1 acc |-> pslverr_o && prdata_o == 32'h0;
  endproperty
  a_low: assert property (p_low)
    else $error("unaligned access not refused");
  property p_idx;
    setup && paddr_i[5:2] > 4'hA ##1 acc |-> pslverr_o && prdata_o == 32'h0;
  endproperty
  a_idx: assert property (p_idx)
    else $error("unused index not refused");
  property p_ok;
    setup && mapped ##1 acc |-> !pslverr_o;
  endproperty
  a_ok: assert property (p_ok)
    else $error("mapped access refused");
  property p_duty;
    setup && mapped && paddr_i[5:2] == REG_DUTY |=> prdata_o <= 32'h64;
  endproperty
  a_duty: assert property (p_duty)
    else $error("duty above one hundred");
  property p_ctrl;
    setup && mapped && paddr_i[5:2] == REG_CTRL |=> prdata_o[31:3] == 29'h0;
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control reads unused bits");
endmodule

// ===== verif/fdm_sensor.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Sensor model: square wave or a held level
// ------------------------------------------------
module fdm_sensor
(
  input wire logic ref_clk_i,
  input wire logic run_i,
  input wire logic lvl_i,
  input wire logic [31:0] per_i,
  input wire logic [31:0] hi_i,
  output logic sig_o
);
  logic [31:0] cnt;
  // Held level mimics a stalled wheel: no edges until run returns
  always_ff @(posedge ref_clk_i)
  begin
    cnt <= (!run_i || cnt >= per_i - 32'h1) ? 32'h0 : cnt + 32'h1;
    sig_o <= run_i ? (cnt < hi_i) : lvl_i;
  end
endmodule

// ===== verif/freq_duty_measure_timeout_test.sv
`timescale 1ns/1ps
module freq_duty_measure_timeout_test;
  import fdm_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sample = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] per = 32'h64;
  logic [31:0] hi = 32'h19;
  logic [1:0] run = 2'h0;
  logic [1:0] lvl = 2'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e;
  wire logic [NUM_CH-1:0] sig;
  int num_errors = 0;
  int check_count = 0;
  // ------------------------------------------------
  // Clock, sensors and the block
  // ------------------------------------------------
  always #10 ref_clk_i = ~ref_clk_i;
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_sen
    fdm_sensor u_sen (.ref_clk_i(ref_clk_i), .run_i(run[i]),
      .lvl_i(lvl[i]), .per_i(per), .hi_i(hi), .sig_o(sig[i]));
  end
  fdm_measure dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .sig_i(sig),
    .sample_i(sample), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  task print_verdict;
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the wait for ready is bounded
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      num_errors++;
      print_verdict;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // Sampling instant is a one-cycle pulse
  task smp;
    @(posedge ref_clk_i);
    sample <= 1'b1;
    @(posedge ref_clk_i);
    sample <= 1'b0;
  endtask
  task t_reset;
    rd(12'h000, 32'h1);
    rd(12'h004, 32'h02FA_F080);
    rd(12'h008, 32'h1);
    $display("reset values done");
  endtask
  task t_period;
    run <= 2'h3;
    repeat (500) @(posedge ref_clk_i);
    smp;
    rd(12'h010, hi);
    rd(12'h014, per - hi);
    rd(12'h018, per);
    rd(12'h01C, 32'(K_FREQ / 40'(per)));
    rd(12'h020, 32'h19);
    rd(12'h024, 32'h0);
    rd(12'h05C, 32'(K_FREQ / 40'(per)));
    $display("period mode done");
  endtask
  // Cycle of four periods, started on the falling edge
  task t_cycle;
    apb(1'b1, 12'h008, 32'h4);
    apb(1'b1, 12'h000, 32'h7);
    repeat (1000) @(posedge ref_clk_i);
    smp;
    rd(12'h028, per * 4);
    rd(12'h01C, 32'(K_FREQ / 40'(per * 4)) * 4);
    rd(12'h024, 32'(K_RPM / 40'(per * 4)));
    rd(12'h01C, 32'h0 + 32'(K_FREQ / 40'(per)));
    $display("cycle mode done");
  endtask
  // Channel 0 stalls high, channel 1 stalls low
  task t_timeout;
    apb(1'b1, 12'h004, 32'h32);
    apb(1'b1, 12'h044, 32'h32);
    lvl <= 2'h1;
    run <= 2'h0;
    repeat (200) @(posedge ref_clk_i);
    smp;
    rd(12'h01C, 32'h0);
    rd(12'h024, 32'h0);
    rd(12'h020, 32'h64);
    rd(12'h060, 32'h0);
    rd(12'h010, 32'h0);
    rd(12'h014, 32'h0);
    rd(12'h018, 32'h0);
    rd(12'h00C, 32'h7);
    rd(12'h058, 32'h0);
    $display("timeout done");
  endtask
  // Period longer than the limit on channel 1, limit off on channel 0
  task t_range;
    per <= 32'hC8;
    hi <= 32'h32;
    apb(1'b1, 12'h044, 32'h96);
    apb(1'b1, 12'h004, 32'h0);
    run <= 2'h3;
    repeat (1600) @(posedge ref_clk_i);
    smp;
    rd(12'h05C, 32'h0);
    rd(12'h01C, 32'(K_FREQ / 40'(per)));
    $display("range done");
  endtask
  task t_unmapped;
    apb(1'b0, 12'h02C, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h082, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("unmapped done");
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset;
    t_period;
    t_cycle;
    t_timeout;
    t_range;
    t_unmapped;
    print_verdict;
  end
endmodule
bind fdm_measure fdm_checker u_chk (.ref_clk_i(ref_clk_i),
  .reset_i(reset_i), .sig_i(sig_i), .sample_i(sample_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o));
